// ### hw/sep_port.sv
`include "sep_params.svh"

module sep_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `SEP_FIFO_DEPTH
) (
	// Clock, reset and flush
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	input  wire logic             i_flush,
	// Fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem[rd_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_comb begin
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (i_flush) begin
			wr_d  = '0;
			rd_d  = '0;
			cnt_d = '0;
		end else begin
			if (push) wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			if (pop) rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; only pointers define contents
	always_ff @(posedge i_clock) begin
		if (push && !i_flush) mem[wr_q] <= i_in_data;
	end
endmodule // sep_fifo

module sep_port #(
	parameter logic [6:0] DEV_ADDR   = `SEP_DEV_ADDR,
	parameter int         FIFO_DEPTH = `SEP_FIFO_DEPTH,
	parameter logic [7:0] FILL_SEED  = 8'hA5
) (
	// Processor side
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_we,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_re,
	output logic      [7:0] o_reg_rdata,
	// Memory side
	input  wire logic       i_link_clock,
	output logic            o_mem_scl,
	output logic            o_mem_sda,
	output logic            o_mem_vdd,
	output logic            o_mem_bus_en_n
);
	// ---------------- Processor domain ----------------
	sep_pkg::sep_ctrl_t ctrl_q, ctrl_d;
	logic [7:0]         rdata_q, rdata_d;
	logic               pull_s1, pull_s2;
	logic               line_sda;
	logic               pull_q;

	// Open-drain wired-and: memory pull and software pull both win over the pull-up
	assign line_sda = ctrl_q.vdd & ctrl_q.sda & ~pull_s2;

	always_comb begin
		ctrl_d  = ctrl_q;
		rdata_d = rdata_q;
		if (i_reg_we && i_reg_addr == `SEP_REG_ADDR) begin
			ctrl_d.scl = i_reg_wdata[`SEP_BIT_SCL];
			ctrl_d.sda = i_reg_wdata[`SEP_BIT_SDA];
			ctrl_d.vdd = i_reg_wdata[`SEP_BIT_VDD];
		end
		if (i_reg_re) begin
			rdata_d = '0;
			if (i_reg_addr == `SEP_REG_ADDR && ctrl_q.vdd) begin
				rdata_d[`SEP_BIT_SCL] = ctrl_q.scl;
				rdata_d[`SEP_BIT_SDA] = line_sda;
				rdata_d[`SEP_BIT_VDD] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q  <= sep_pkg::sep_ctrl_t'(`SEP_REG_RESET);
			rdata_q <= '0;
			pull_s1 <= 1'b0;
			pull_s2 <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
			pull_s1 <= pull_q;
			pull_s2 <= pull_s1;
		end
	end

	assign o_reg_rdata    = rdata_q;
	assign o_mem_scl      = ctrl_q.vdd & ctrl_q.scl;
	assign o_mem_sda      = line_sda;
	assign o_mem_vdd      = ctrl_q.vdd;
	assign o_mem_bus_en_n = ~ctrl_q.vdd;

	// ---------------- Memory domain ----------------
	sep_pkg::sep_ctrl_t lk_s1, lk_s2;
	logic                scl_p, sda_p;
	sep_pkg::sep_state_t st_q, st_d;
	logic [2:0]          cnt_q, cnt_d;
	logic [7:0]          sh_q, sh_d;
	logic                pull_d;
	logic                is_ctrl_q, is_ctrl_d, rd_q, rd_d, wa_q, wa_d, mack_q, mack_d;
	logic [`SEP_MEM_AW-1:0] ptr_q, ptr_d;
	logic [7:0]          mem [`SEP_MEM_DEPTH];
	logic                scl_rise, scl_fall, start_c, stop_c, off;
	logic                f_in_valid, f_in_ready, f_out_valid, f_out_ready, load;
	logic [7:0]          f_out_data;

	// Contents stand in for nonvolatile data; writes into the array are not built
	initial begin
		for (int i = 0; i < `SEP_MEM_DEPTH; i++) mem[i] = 8'(i) ^ FILL_SEED;
	end

	assign off      = ~lk_s2.vdd;
	assign scl_rise = lk_s2.scl & ~scl_p;
	assign scl_fall = ~lk_s2.scl & scl_p;
	assign start_c  = lk_s2.scl & scl_p & sda_p & ~lk_s2.sda;
	assign stop_c   = lk_s2.scl & scl_p & ~sda_p & lk_s2.sda;

	sep_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_addr_fifo (
		.i_clock     (i_link_clock),
		.i_rst       (i_rst),
		.i_flush     (off),
		.i_in_valid  (f_in_valid),
		.o_in_ready  (f_in_ready),
		.i_in_data   (sh_q),
		.o_out_valid (f_out_valid),
		.i_out_ready (f_out_ready),
		.o_out_data  (f_out_data)
	);

	// Pointer load waits while a byte is being fetched so the two never collide
	assign f_out_ready = ~load;

	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		sh_d       = sh_q;
		pull_d     = pull_q;
		is_ctrl_d  = is_ctrl_q;
		rd_d       = rd_q;
		wa_d       = wa_q;
		mack_d     = mack_q;
		ptr_d      = ptr_q;
		f_in_valid = 1'b0;
		load       = 1'b0;
		if (start_c) begin
			st_d      = sep_pkg::SEP_RX;
			cnt_d     = '0;
			pull_d    = 1'b0;
			is_ctrl_d = 1'b1;
			wa_d      = 1'b0;
		end else if (stop_c) begin
			st_d   = sep_pkg::SEP_IDLE;
			pull_d = 1'b0;
		end else begin
			unique case (st_q)
				sep_pkg::SEP_IDLE: ;
				sep_pkg::SEP_RX: if (scl_rise) begin
					sh_d  = {sh_q[6:0], lk_s2.sda};
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == `SEP_LAST_BIT) st_d = sep_pkg::SEP_RX_DONE;
				end
				sep_pkg::SEP_RX_DONE: if (scl_fall) begin
					st_d = sep_pkg::SEP_ACK;
					if (is_ctrl_q) begin
						pull_d = (sh_q[7:1] == DEV_ADDR);
						rd_d   = sh_q[0];
						wa_d   = ~sh_q[0];
					end else if (wa_q) begin
						f_in_valid = 1'b1;
						pull_d     = f_in_ready;
						wa_d       = 1'b0;
					end else begin
						// Write data is acked and dropped; the pointer still moves past it
						load   = 1'b1;
						pull_d = 1'b1;
						ptr_d  = ptr_q + `SEP_MEM_AW'(1);
					end
					if (!pull_d) st_d = sep_pkg::SEP_IDLE;
				end
				sep_pkg::SEP_ACK: if (scl_fall) begin
					is_ctrl_d = 1'b0;
					cnt_d     = '0;
					if (rd_q) begin
						load   = 1'b1;
						sh_d   = mem[ptr_q];
						pull_d = ~mem[ptr_q][7];
						ptr_d  = ptr_q + `SEP_MEM_AW'(1);
						st_d   = sep_pkg::SEP_TX;
					end else begin
						pull_d = 1'b0;
						st_d   = sep_pkg::SEP_RX;
					end
				end
				sep_pkg::SEP_TX: if (scl_fall) begin
					if (cnt_q == `SEP_LAST_BIT) begin
						pull_d = 1'b0;
						st_d   = sep_pkg::SEP_TX_ACK;
					end else begin
						sh_d   = {sh_q[6:0], 1'b0};
						pull_d = ~sh_q[6];
						cnt_d  = cnt_q + 3'h1;
					end
				end
				sep_pkg::SEP_TX_ACK: begin
					if (scl_rise) mack_d = ~lk_s2.sda;
					if (scl_fall) begin
						if (mack_q) begin
							load   = 1'b1;
							cnt_d  = '0;
							sh_d   = mem[ptr_q];
							pull_d = ~mem[ptr_q][7];
							ptr_d  = ptr_q + `SEP_MEM_AW'(1);
							st_d   = sep_pkg::SEP_TX;
						end else begin
							st_d = sep_pkg::SEP_IDLE;
						end
					end
				end
				default: st_d = sep_pkg::SEP_IDLE;
			endcase
		end
		if (f_out_valid && !load) ptr_d = f_out_data[`SEP_MEM_AW-1:0];
		if (off) begin
			st_d   = sep_pkg::SEP_IDLE;
			pull_d = 1'b0;
			ptr_d  = '0;
		end
	end

	always_ff @(posedge i_link_clock or posedge i_rst) begin
		if (i_rst) begin
			// Match the register's reset level so no false edge follows reset
			lk_s1     <= sep_pkg::sep_ctrl_t'(`SEP_REG_RESET);
			lk_s2     <= sep_pkg::sep_ctrl_t'(`SEP_REG_RESET);
			scl_p     <= 1'b1;
			sda_p     <= 1'b1;
			st_q      <= sep_pkg::SEP_IDLE;
			cnt_q     <= '0;
			sh_q      <= '0;
			pull_q    <= 1'b0;
			is_ctrl_q <= 1'b0;
			rd_q      <= 1'b0;
			wa_q      <= 1'b0;
			mack_q    <= 1'b0;
			ptr_q     <= '0;
		end else begin
			lk_s1     <= ctrl_q;
			lk_s2     <= lk_s1;
			scl_p     <= lk_s2.scl;
			sda_p     <= lk_s2.sda;
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			sh_q      <= sh_d;
			pull_q    <= pull_d;
			is_ctrl_q <= is_ctrl_d;
			rd_q      <= rd_d;
			wa_q      <= wa_d;
			mack_q    <= mack_d;
			ptr_q     <= ptr_d;
		end
	end
endmodule // sep_port

// ### hw/sep_params.svh
// Function
// - Memory holds 128 bytes reached only over a two-wire data and clock bus.
// - Data line sits at bit 1 and clock line at bit 2 of the port register.
// - Data line carries addresses and data both ways; clock paces every transfer.
// - Clock-drive bit 1 drives clock high, 0 drives it low.
// - Data-drive bit 0 pulls data low, 1 releases it to the pull-up.
// - Power bit powers the memory; cleared, memory is off and pins float.
// - With power off the clock, data and power bits all read zero.
// - A read starts like a write but with direction bit one.
// - Internal counter holds last address plus one for current-address reads.
// - Addressed with direction one, the memory acknowledges and sends one byte.
// - Master withholding acknowledge then stopping ends the read; memory stops sending.
// - Start after the acked word address abandons the write, pointer already loaded.
// - Control byte resent with direction one returns the addressed byte.
// - Master acknowledging each byte makes the memory send the byte at the next address.
// - Pointer advances by one at the end of each byte operation.
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH
`define SEP_REG_ADDR     8'h90
`define SEP_BIT_VDD      0
`define SEP_BIT_SDA      1
`define SEP_BIT_SCL      2
`define SEP_REG_RESET    3'h7
`define SEP_MEM_DEPTH    128
`define SEP_MEM_AW       7
`define SEP_DEV_ADDR     7'h50
`define SEP_FIFO_DEPTH   16
`define SEP_LAST_BIT     3'h7
`endif

// ### hw/sep_pkg.sv
package sep_pkg;
	typedef struct packed {
		logic scl;
		logic sda;
		logic vdd;
	} sep_ctrl_t;

	typedef enum logic [2:0] {
		SEP_IDLE    = 3'b000,
		SEP_RX      = 3'b001,
		SEP_RX_DONE = 3'b010,
		SEP_ACK     = 3'b011,
		SEP_TX      = 3'b100,
		SEP_TX_ACK  = 3'b101
	} sep_state_t;
endpackage

// ### verif/sep_port_checker.sv
module sep_port_checker (
	// Watched ports
	input wire logic       i_clock,
	input wire logic       i_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic       i_reg_we,
	input wire logic [7:0] i_reg_wdata,
	input wire logic       i_reg_re,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_mem_scl,
	input wire logic       o_mem_sda,
	input wire logic       o_mem_vdd,
	input wire logic       o_mem_bus_en_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr_hit;
	logic rd_hit;
	assign wr_hit = i_reg_we && (i_reg_addr == 8'h90);
	assign rd_hit = i_reg_re && (i_reg_addr == 8'h90);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	a_pwr_on: assert property (wr_hit && i_reg_wdata[0] |=> o_mem_vdd && !o_mem_bus_en_n)
		else $error("power on not applied");
	a_pwr_off: assert property (wr_hit && !i_reg_wdata[0] |=> !o_mem_vdd)
		else $error("power off not applied");
	a_off_float: assert property (!o_mem_vdd |-> o_mem_bus_en_n && !o_mem_scl)
		else $error("pins driven while unpowered");
	a_scl_hi: assert property (wr_hit && i_reg_wdata[2] && i_reg_wdata[0] |=> o_mem_scl)
		else $error("clock line not high");
	a_scl_lo: assert property (wr_hit && !i_reg_wdata[2] |=> !o_mem_scl)
		else $error("clock line not low");
	a_sda_pull: assert property (wr_hit && i_reg_wdata[1:0] == 2'h1 |=> !o_mem_sda)
		else $error("data line not pulled low");
	a_off_reads: assert property (rd_hit && !o_mem_vdd |=> o_reg_rdata == 8'h00)
		else $error("read while unpowered not zero");
	a_reg_map: assert property (rd_hit && o_mem_vdd |=>
		o_reg_rdata[2] == $past(o_mem_scl) && o_reg_rdata[0] && o_reg_rdata[7:3] == 5'h00)
		else $error("register bits misplaced");
	a_unmapped: assert property (i_reg_re && i_reg_addr != 8'h90 |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // sep_port_checker

// ### verif/sep_line_model.sv
module sep_line_model (
	// Pin side of the port
	input  wire logic i_sda,
	input  wire logic i_bus_en_n,
	// Level on the wire
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up wins whenever the port floats its pins
	assign o_line = i_bus_en_n ? 1'b1 : i_sda;
endmodule // sep_line_model

// ### verif/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] FILL = 8'h3C;
	logic       i_clock = 0;
	logic       i_rst = 1;
	logic       i_link_clock = 0;
	logic [7:0] addr = 0;
	logic       we = 0;
	logic [7:0] wd = 0;
	logic       re = 0;
	logic [7:0] rdata;
	logic       scl, sda, vdd, en_n, line;
	logic [7:0] exp_q[$];
	logic       pend = 0;
	int         error_cnt = 0;
	int         tests_run = 0;
	int         cyc = 0;
	int         seed = 32'haf30;
	logic [7:0] ra;
	always #10 i_clock = ~i_clock;
	always #3 i_link_clock = ~i_link_clock;
	sep_port #(.FILL_SEED(FILL)) dut (.i_clock, .i_rst, .i_reg_addr(addr), .i_reg_we(we),
		.i_reg_wdata(wd), .i_reg_re(re), .o_reg_rdata(rdata), .i_link_clock,
		.o_mem_scl(scl), .o_mem_sda(sda), .o_mem_vdd(vdd), .o_mem_bus_en_n(en_n));
	sep_line_model u_line (.i_sda(sda), .i_bus_en_n(en_n), .o_line(line));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// One register access; for a read, d is the expected value
	task automatic acc(logic [7:0] a, logic w, logic [7:0] d);
		@(negedge i_clock);
		addr = a;
		we = w;
		re = !w;
		wd = d;
		if (!w) exp_q.push_back(d);
		@(negedge i_clock);
		we = 0;
		re = 0;
	endtask
	// Each bus phase is held long enough for the memory side to see it
	task automatic b(logic c, logic s);
		acc(8'h90, 1, {5'h00, c, s, 1'b1});
		repeat (10) @(negedge i_clock);
	endtask
	task automatic bt(logic v, logic c, logic e);
		b(0, v);
		b(1, v);
		if (c) acc(8'h90, 0, {5'h00, 1'b1, e, 1'b1});
		b(0, v);
	endtask
	task automatic st;
		b(0, 1);
		b(1, 1);
		b(1, 0);
		b(0, 0);
	endtask
	task automatic sp;
		b(0, 0);
		b(1, 0);
		b(1, 1);
	endtask
	task automatic tx(logic [7:0] d, logic ak);
		for (int i = 7; i >= 0; i--) bt(d[i], 0, 0);
		bt(1, 1, ak);
	endtask
	task automatic rx(logic [7:0] e, logic last);
		for (int i = 7; i >= 0; i--) bt(1, 1, e[i]);
		bt(last, 0, 0);
	endtask
	task automatic cur(logic [6:0] a);
		st();
		tx(8'hA1, 0);
		rx({1'b0, a} ^ FILL, 1);
		sp();
	endtask
	task automatic seq(logic [6:0] a, int n);
		logic [6:0] w;
		st();
		tx(8'hA0, 0);
		tx({1'b0, a}, 0);
		st();
		tx(8'hA1, 0);
		for (int k = 0; k < n; k++) begin
			w = a + k[6:0];
			rx({1'b0, w} ^ FILL, k == n - 1);
		end
		sp();
	endtask
	always @(posedge i_clock) pend <= re;
	always @(negedge i_clock) if (pend) chk("rdata", rdata, exp_q.pop_front());
	always @(posedge i_clock) begin
		cyc++;
		if (cyc > 40000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		repeat (2) @(posedge i_clock);
		@(negedge i_clock);
		i_rst = 0;
		repeat (8) @(negedge i_clock);
		acc(8'h90, 0, 8'h07);
		ra = $random(seed);
		acc({1'b0, ra[6:0]}, 1, ra);
		acc({1'b0, ra[6:0]}, 0, 8'h00);
		acc(8'h90, 0, 8'h07);
		cur(7'h00);
		seq(7'h7F, 3);
		cur(7'h02);
		seq(ra[6:0], 1);
		cur(ra[6:0] + 7'h01);
		// A written data byte is acked and still moves the pointer on
		st();
		tx(8'hA0, 0);
		tx(8'h10, 0);
		tx(ra, 0);
		sp();
		cur(7'h11);
		// Foreign device address gets no acknowledge
		st();
		tx(8'hB4, 1);
		sp();
		acc(8'h90, 1, 8'h06);
		acc(8'h90, 0, 8'h00);
		chk("line", {7'h00, line}, 8'h01);
		acc(8'h90, 1, 8'h07);
		repeat (10) @(negedge i_clock);
		cur(7'h00);
		repeat (4) @(negedge i_clock);
		wrap_up();
	end
endmodule // tb_top

bind sep_port sep_port_checker u_chk (.i_clock, .i_rst, .i_reg_addr, .i_reg_we,
	.i_reg_wdata, .i_reg_re, .o_reg_rdata, .o_mem_scl, .o_mem_sda, .o_mem_vdd,
	.o_mem_bus_en_n);
